// ===== hdl/tfw_pkg.sv
// constants and types for the tunable filter write-group register bank
package tfw_pkg;
  // ==========================================================
  // bus and register geometry
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_SLOTS = 4;
  localparam int unsigned NUM_BANDS = 4;
  localparam int unsigned PTR_W = 7;

  // ==========================================================
  // register offsets
  localparam logic [14:0] ADDR_PTR = 15'h010;
  localparam logic [14:0] ADDR_SEQ_STATE = 15'h014;
  localparam logic [14:0] ADDR_G2_SW = 15'h024;
  localparam logic [14:0] ADDR_G2_FLT = 15'h025;
  localparam logic [14:0] ADDR_G3_SW = 15'h026;
  localparam logic [14:0] ADDR_G3_FLT = 15'h027;
  localparam logic [14:0] ADDR_G4_SW = 15'h028;
  localparam logic [14:0] ADDR_G4_FLT = 15'h029;
  localparam logic [14:0] ADDR_E0_SW = 15'h100;
  localparam logic [14:0] ADDR_E0_FLT = 15'h101;

  // ==========================================================
  // field positions and codes
  localparam int unsigned PTR_LOAD_BIT = 7;
  localparam logic [2:0] POS_BYPASS = 3'h0;
  localparam logic [2:0] POS_BAND4 = 3'h4;
  localparam logic [1:0] SLOT_ENTRY0 = 2'h3;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [6:0] RST_PTR = 7'h00;
  localparam logic [3:0] RST_STATE = 4'h0;

  // switch register layout
  typedef struct packed {
    logic in_apply;
    logic out_apply;
    logic [2:0] in_pos;
    logic [2:0] out_pos;
  } tfw_sw_t;

  // filter register layout
  typedef struct packed {
    logic [3:0] highpass;
    logic [3:0] lowpass;
  } tfw_flt_t;

  // register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [14:0] addr;
    logic [7:0] wdata;
  } tfw_req_t;
endpackage

// ===== hdl/tfw_regs.sv
// write-group and table-entry register bank with band switch outputs
`timescale 1ns/10ps
`default_nettype none
module tfw_regs
  import tfw_pkg::*;
(
  input wire logic MCLK_I, // 25 MHz clock
  input wire logic RESET_I, // synchronous reset, active high
  input wire logic WR_I, // register write strobe
  input wire logic RD_I, // register read strobe
  input wire logic [14:0] ADDR_I, // register address
  input wire logic [7:0] WDATA_I, // write data
  output logic [7:0] RDATA_O, // read data, registered
  output logic RVALID_O, // read data valid pulse
  output logic [2:0] IN_SWITCH_O, // input band switch position
  output logic [2:0] OUT_SWITCH_O, // output band switch position
  output logic [15:0] HIGHPASS_O, // high-pass states, band n at [4n-1:4n-4]
  output logic [15:0] LOWPASS_O, // low-pass states, band n at [4n-1:4n-4]
  output logic [6:0] SEQ_POINTER_O // sequencer pointer
);

  // ==========================================================
  // decode helpers
  // slot index of a switch or filter address, valid flag in bit 2
  function automatic logic [2:0] slot_of(input logic [14:0] a);
    unique case (a)
      ADDR_G2_SW, ADDR_G2_FLT: slot_of = 3'h4;
      ADDR_G3_SW, ADDR_G3_FLT: slot_of = 3'h5;
      ADDR_G4_SW, ADDR_G4_FLT: slot_of = 3'h6;
      ADDR_E0_SW, ADDR_E0_FLT: slot_of = 3'h7;
      // anything else has no slot: apart from the pointer and state registers, writes dropped, reads zero
      default: slot_of = 3'h0;
    endcase
  endfunction

  // a defined band code, bypass excluded
  function automatic logic is_band(input logic [2:0] p);
    is_band = (p != POS_BYPASS) && (p <= POS_BAND4);
  endfunction

  // a defined switch code, bypass included; others are left alone
  function automatic logic is_pos(input logic [2:0] p);
    is_pos = (p <= POS_BAND4);
  endfunction

  // band index of a defined band code, band one at index zero
  function automatic logic [1:0] band_idx(input logic [2:0] p);
    band_idx = 2'(p - 3'h1);
  endfunction

  // pointer register address, decoded for write, load and read
  function automatic logic is_ptr(input logic [14:0] a);
    is_ptr = (a == ADDR_PTR);
  endfunction

  // ==========================================================
  // state
  // per-slot register contents
  tfw_sw_t sw_ff [NUM_SLOTS];
  tfw_flt_t flt_ff [NUM_SLOTS];
  tfw_sw_t nxt_sw [NUM_SLOTS];
  tfw_flt_t nxt_flt [NUM_SLOTS];
  // per-band filter states
  logic [3:0] hp_ff [NUM_BANDS];
  logic [3:0] lp_ff [NUM_BANDS];
  logic [3:0] nxt_hp [NUM_BANDS];
  logic [3:0] nxt_lp [NUM_BANDS];
  // switch positions and pointers
  logic [2:0] in_sw_ff;
  logic [2:0] nxt_in_sw;
  logic [2:0] out_sw_ff;
  logic [2:0] nxt_out_sw;
  logic [6:0] ptr_ff;
  logic [6:0] nxt_ptr;
  logic [6:0] seq_ff;
  logic [6:0] nxt_seq;
  // read port
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic rvalid_ff;
  logic nxt_rvalid;
  // request decode
  tfw_req_t req;
  logic [2:0] slot_code;
  logic [1:0] slot;
  logic hit;
  logic is_flt;

  // request bundle and slot decode
  assign req = '{wr: WR_I, rd: RD_I, addr: ADDR_I, wdata: WDATA_I};
  assign slot_code = slot_of(req.addr);
  assign hit = slot_code[2];
  assign slot = slot_code[1:0];
  assign is_flt = req.addr[0];

  // ==========================================================
  // write decode, shared by storage and application
  logic sw_write;
  logic flt_write;
  logic ptr_write;

  // each strobe is decoded once so both users agree
  assign sw_write = req.wr && hit && !is_flt;
  assign flt_write = req.wr && hit && is_flt;
  assign ptr_write = req.wr && is_ptr(req.addr);

  // ==========================================================
  // register storage next state
  always_comb begin
    for (int i = 0; i < NUM_SLOTS; i++) begin
      nxt_sw[i] = sw_ff[i];
      nxt_flt[i] = flt_ff[i];
    end
    nxt_ptr = ptr_ff;
    // undefined position codes are stored as written
    if (sw_write) begin
      nxt_sw[slot] = tfw_sw_t'(req.wdata);
    end
    if (flt_write) begin
      nxt_flt[slot] = tfw_flt_t'(req.wdata);
    end
    // load bit is not stored, so it always reads back zero
    if (ptr_write) begin
      nxt_ptr = req.wdata[6:0];
    end
  end

  // register storage flops
  // reset clears every field to zero, meaning bypass
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        sw_ff[i] <= tfw_sw_t'(RST_REG);
        flt_ff[i] <= tfw_flt_t'(RST_REG);
      end
      ptr_ff <= RST_PTR;
    end else begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        sw_ff[i] <= nxt_sw[i];
        flt_ff[i] <= nxt_flt[i];
      end
      ptr_ff <= nxt_ptr;
    end
  end

  // ==========================================================
  // switch and filter state application
  tfw_sw_t app_sw;
  tfw_flt_t app_flt;
  logic app_sw_en;
  logic app_flt_en;
  logic load_seq;

  // which register contents act on the hardware this cycle
  // a filter write steers by the stored positions, apply bits or not
  always_comb begin
    load_seq = ptr_write && req.wdata[PTR_LOAD_BIT];
    app_sw = tfw_sw_t'(req.wdata);
    app_flt = tfw_flt_t'(req.wdata);
    app_sw_en = sw_write;
    app_flt_en = 1'b0;
    if (flt_write) begin
      // band choice comes from the same group's switch register
      app_sw = nxt_sw[slot];
      app_flt_en = 1'b1;
    end
    if (load_seq && req.wdata[6:0] == RST_PTR) begin
      // sequencer landing on entry zero applies that entry
      app_sw = sw_ff[SLOT_ENTRY0];
      app_flt = flt_ff[SLOT_ENTRY0];
      app_sw_en = 1'b1;
      app_flt_en = 1'b1;
    end
  end

  // next switch positions and per-band states
  always_comb begin
    nxt_in_sw = in_sw_ff;
    nxt_out_sw = out_sw_ff;
    for (int b = 0; b < NUM_BANDS; b++) begin
      nxt_hp[b] = hp_ff[b];
      nxt_lp[b] = lp_ff[b];
    end
    // undefined codes leave a switch where it was
    if (app_sw_en && app_sw.in_apply && is_pos(app_sw.in_pos)) begin
      nxt_in_sw = app_sw.in_pos;
    end
    if (app_sw_en && app_sw.out_apply && is_pos(app_sw.out_pos)) begin
      nxt_out_sw = app_sw.out_pos;
    end
    // bypass and undefined codes change no band state
    if (app_flt_en && is_band(app_sw.in_pos)) begin
      nxt_hp[band_idx(app_sw.in_pos)] = app_flt.highpass;
    end
    if (app_flt_en && is_band(app_sw.out_pos)) begin
      nxt_lp[band_idx(app_sw.out_pos)] = app_flt.lowpass;
    end
  end

  // switch and band state flops
  // reset leaves both switches in bypass
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      in_sw_ff <= POS_BYPASS;
      out_sw_ff <= POS_BYPASS;
      for (int b = 0; b < NUM_BANDS; b++) begin
        hp_ff[b] <= RST_STATE;
        lp_ff[b] <= RST_STATE;
      end
    end else begin
      in_sw_ff <= nxt_in_sw;
      out_sw_ff <= nxt_out_sw;
      for (int b = 0; b < NUM_BANDS; b++) begin
        hp_ff[b] <= nxt_hp[b];
        lp_ff[b] <= nxt_lp[b];
      end
    end
  end

  // ==========================================================
  // sequencer pointer
  // any value loads; only pointer zero has a table entry here
  always_comb begin
    nxt_seq = seq_ff;
    if (load_seq) begin
      nxt_seq = req.wdata[6:0];
    end
  end

  // sequencer pointer flop
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      seq_ff <= RST_PTR;
    end else begin
      seq_ff <= nxt_seq;
    end
  end

  // ==========================================================
  // read path
  always_comb begin
    nxt_rvalid = req.rd;
    nxt_rdata = rdata_ff;
    // read data holds between reads; unmapped addresses read zero
    if (req.rd) begin
      nxt_rdata = RST_REG;
      if (hit && !is_flt) begin
        nxt_rdata = 8'(sw_ff[slot]);
      end else if (hit) begin
        nxt_rdata = 8'(flt_ff[slot]);
      end else if (is_ptr(req.addr)) begin
        nxt_rdata = {1'b0, ptr_ff}; // load bit reads zero
      end else if (req.addr == ADDR_SEQ_STATE) begin
        nxt_rdata = {1'b0, seq_ff};
      end
    end
  end

  // read data flops
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      rdata_ff <= RST_REG;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // ==========================================================
  // outputs, one nibble per band
  for (genvar b = 0; b < NUM_BANDS; b++) begin : g_band
    assign HIGHPASS_O[4*b +: 4] = hp_ff[b];
    assign LOWPASS_O[4*b +: 4] = lp_ff[b];
  end

  // switch positions
  assign IN_SWITCH_O = in_sw_ff;
  assign OUT_SWITCH_O = out_sw_ff;

  // sequencer pointer
  assign SEQ_POINTER_O = seq_ff;

  // read port
  assign RDATA_O = rdata_ff;
  assign RVALID_O = rvalid_ff;

endmodule
`default_nettype wire

// ===== testbench/tfw_regs_properties.sv
// checker for the register bank ports
`timescale 1ns/10ps
`default_nettype none
module tfw_regs_properties
  import tfw_pkg::*;
(
  input wire logic MCLK_I, // clock
  input wire logic RESET_I, // sync reset
  input wire logic WR_I, // write strobe
  input wire logic RD_I, // read strobe
  input wire logic [14:0] ADDR_I, // address
  input wire logic [7:0] WDATA_I, // write data
  input wire logic [7:0] RDATA_O, // read data
  input wire logic RVALID_O, // read valid
  input wire logic [2:0] IN_SWITCH_O, // input switch
  input wire logic [2:0] OUT_SWITCH_O, // output switch
  input wire logic [6:0] SEQ_POINTER_O // pointer
);
  // ==========================================================
  // helpers
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);
  logic sw_wr;
  logic ptr_wr;
  // write to any group switch register
  assign sw_wr = WR_I && (ADDR_I == ADDR_G2_SW || ADDR_I == ADDR_G3_SW ||
    ADDR_I == ADDR_G4_SW);
  assign ptr_wr = WR_I && ADDR_I == ADDR_PTR;
  // ==========================================================
  // assertions
  a_read_answers: assert property (RD_I |=> RVALID_O)
    else $error("read not answered");
  a_valid_single: assert property (!RD_I |=> !RVALID_O)
    else $error("valid without read");
  a_in_apply: assert property (sw_wr && WDATA_I[7] &&
    WDATA_I[5:3] <= POS_BAND4 |=> IN_SWITCH_O == $past(WDATA_I[5:3]))
    else $error("input switch not applied");
  a_out_apply: assert property (sw_wr && WDATA_I[6] &&
    WDATA_I[2:0] <= POS_BAND4 |=> OUT_SWITCH_O == $past(WDATA_I[2:0]))
    else $error("output switch not applied");
  a_in_hold: assert property (sw_wr && !WDATA_I[7] |=>
    $stable(IN_SWITCH_O)) else $error("input switch moved");
  a_out_hold: assert property (sw_wr && !WDATA_I[6] |=>
    $stable(OUT_SWITCH_O)) else $error("output switch moved");
  a_ptr_load: assert property (ptr_wr && WDATA_I[7] |=>
    SEQ_POINTER_O == $past(WDATA_I[6:0])) else $error("pointer not loaded");
  a_load_clears: assert property (ptr_wr && WDATA_I[7] ##1
    !WR_I ##1 RD_I && !WR_I && ADDR_I == ADDR_PTR |=>
    RDATA_O == {1'b0, $past(WDATA_I[6:0], 3)}) else $error("load bit stuck");
  a_unmapped_zero: assert property (RD_I && ADDR_I == 15'h02a |=>
    RDATA_O == 8'h00) else $error("unmapped read not zero");
endmodule
bind tfw_regs tfw_regs_properties chk (.MCLK_I(MCLK_I), .RESET_I(RESET_I),
  .WR_I(WR_I), .RD_I(RD_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .RDATA_O(RDATA_O), .RVALID_O(RVALID_O), .IN_SWITCH_O(IN_SWITCH_O),
  .OUT_SWITCH_O(OUT_SWITCH_O), .SEQ_POINTER_O(SEQ_POINTER_O));
`default_nettype wire

// ===== testbench/tfw_host.sv
// host controller model driving the register bus
`timescale 1ns/10ps
`default_nettype none
module tfw_host
  import tfw_pkg::*;
(
  input wire logic clk_i, // bus clock
  input wire logic [7:0] rdata_i, // read data
  input wire logic rvalid_i, // read valid
  output var tfw_req_t req_o // bus request
);
  // ==========================================================
  // bus cycles, one strobe cycle each, callers keep positions 0..4
  initial req_o = '0;
  // single write, effect visible on return
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    @(posedge clk_i) #1;
    req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i) #1;
    req_o.wr = 1'b0;
  endtask
  // single read, data and valid taken one cycle after the strobe
  task automatic rd(input logic [14:0] a, output logic [7:0] d,
    output logic v);
    @(posedge clk_i) #1;
    req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i) #1;
    d = rdata_i;
    v = rvalid_i;
    req_o.rd = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== testbench/tunable_filter_write_groups_test.sv
// self-checking bench for the register bank
`timescale 1ns/10ps
`default_nettype none
module tunable_filter_write_groups_test;
  import tfw_pkg::*;
  localparam logic [14:0] MAP [8] = '{ADDR_G2_SW, ADDR_G2_FLT, ADDR_G3_SW,
    ADDR_G3_FLT, ADDR_G4_SW, ADDR_G4_FLT, ADDR_E0_SW, ADDR_E0_FLT};
  logic clk, rst, vld, rvalid;
  logic [7:0] d, rdata;
  logic [2:0] in_sw, out_sw;
  logic [15:0] hp, lp;
  logic [6:0] ptr;
  tfw_req_t req;
  int n_mismatch = 0;
  int checked = 0;
  tfw_host h (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));
  tfw_regs uut (.MCLK_I(clk), .RESET_I(rst), .WR_I(req.wr), .RD_I(req.rd),
    .ADDR_I(req.addr), .WDATA_I(req.wdata), .RDATA_O(rdata),
    .RVALID_O(rvalid), .IN_SWITCH_O(in_sw), .OUT_SWITCH_O(out_sw),
    .HIGHPASS_O(hp), .LOWPASS_O(lp), .SEQ_POINTER_O(ptr));
  // ==========================================================
  // helpers
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // read with valid folded into the compare
  task automatic rchk(input logic [14:0] a, input logic [7:0] e);
    h.rd(a, d, vld);
    chk({7'h00, vld, d}, {8'h01, e});
  endtask
  task automatic summarize;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========================================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #100000;
    n_mismatch++;
    summarize();
  end
  // ==========================================================
  // tests
  initial begin
    rst = 1'b1;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    foreach (MAP[i]) rchk(MAP[i], 8'h00);
    chk(hp | lp | 16'({in_sw, out_sw, ptr}), 16'h0000);
    foreach (MAP[i]) h.wr(MAP[i],
      {1'b0, i[0], 3'(i % 5), 3'(4 - i % 5)});
    foreach (MAP[i]) rchk(MAP[i],
      {1'b0, i[0], 3'(i % 5), 3'(4 - i % 5)});
    h.wr(15'h02a, 8'h5a);
    rchk(15'h02a, 8'h00);
    // every band code on both switches, then the states it steers
    for (int p = 1; p <= 4; p++) begin
      h.wr(ADDR_G4_SW, {2'b11, 3'(p), 3'(5 - p)});
      chk(16'({in_sw, out_sw}), 16'({3'(p), 3'(5 - p)}));
      h.wr(ADDR_G4_FLT, {4'(p + 10), 4'(p + 3)});
      chk(16'({hp[4*p-1 -: 4], lp[4*(5-p)-1 -: 4]}),
        16'({4'(p + 10), 4'(p + 3)}));
    end
    h.wr(ADDR_G4_SW, 8'hc0);
    chk(16'({in_sw, out_sw}), 16'h0000);
    h.wr(ADDR_G3_SW, 8'h1b);
    chk(16'({in_sw, out_sw}), 16'h0000);
    h.wr(ADDR_PTR, 8'h85);
    chk(16'(ptr), 16'h0005);
    rchk(ADDR_PTR, 8'h05);
    rchk(ADDR_SEQ_STATE, 8'h05);
    h.wr(ADDR_E0_SW, 8'hd3);
    h.wr(ADDR_E0_FLT, 8'h7e);
    // park the switches and clear the bands the entry must restore
    h.wr(ADDR_G3_SW, 8'h13);
    h.wr(ADDR_G3_FLT, 8'h00);
    h.wr(ADDR_G4_SW, 8'hc0);
    chk(16'({in_sw, out_sw, hp[7:4], lp[11:8]}), 16'h0000);
    h.wr(ADDR_PTR, 8'h80);
    rchk(ADDR_PTR, 8'h00);
    chk(16'({in_sw, out_sw, ptr}), 16'({3'h2, 3'h3, 7'h00}));
    chk(16'({hp[7:4], lp[11:8]}), 16'h007e);
    // reset in mid-run clears registers and outputs again
    @(posedge clk) #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    rchk(ADDR_E0_FLT, 8'h00);
    chk(hp | lp | 16'({in_sw, out_sw, ptr}), 16'h0000);
    summarize();
  end
endmodule
`default_nettype wire
